// file: hw/sbt_timer.sv
// Purpose: 16-bit up timer with compare and capture, behind an Avalon-MM slave
// Assumes: capture pin and carrier flip-flop are synchronous to sys_clk
// Notes: overflow request is a one-cycle pulse, match/capture request a level while pending, to an outside controller
`timescale 1ns/100ps
`include "sbt_map.svh"

// Contract
// - one 16-bit up counter steps on each selected tick, feeds a comparator
// - tick is oscillator divided by 4, 8, 16 or the carrier flip-flop
// - reset clears control: divide by 4, interval mode, interrupts off
// - with overflow enabled, request overflow interrupt on a tick while the counter is all ones
// - after the overflow request the counter clears and keeps counting
// - writing one to the clear bit zeroes the counter; zero does nothing
// - interval mode raises match interrupt when count equals the reference
// - comparator match exists only in interval mode
// - on a match the counter clears and counts up from zero
// - capture modes raise interrupt on rising, falling or both pin edges
// - overflow request wins over match/capture request when both pend
// - separate enable bits for overflow and match/capture interrupts
// - pending bit reads one when set; software writes zero to clear
// - counter high and low bytes are read-only; writes ignored
// - reference high and low bytes are read/write, forming the compare value
module sbt_timer #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic capture_input_pin,
    input wire logic carrier_ff,
    output logic overflow_event,
    output logic match_capture_req,
    output logic timer_interrupt_level
);
    sbt_pkg::sbt_state_t s_ff;
    sbt_pkg::sbt_state_t nxt_s;

    // only the low six index bits fit the 8-bit byte address
    localparam logic [7:0] ADR_CNT_HIGH = {6'(`SBT_IDX_CNT_HIGH), 2'b00};
    localparam logic [7:0] ADR_CNT_LOW = {6'(`SBT_IDX_CNT_LOW), 2'b00};
    localparam logic [7:0] ADR_REF_HIGH = {6'(`SBT_IDX_REF_HIGH), 2'b00};
    localparam logic [7:0] ADR_REF_LOW = {6'(`SBT_IDX_REF_LOW), 2'b00};
    localparam logic [7:0] ADR_CONTROL = {6'(`SBT_IDX_CONTROL), 2'b00};
    localparam logic [7:0] ADR_STATUS = {6'(`SBT_IDX_IRQ_STATUS), 2'b00};
    localparam logic [7:0] ADR_MASK = {6'(`SBT_IDX_IRQ_MASK), 2'b00};

    logic tick;
    logic cap_hit;
    logic match_hit;
    logic at_top;
    logic ctl_wr;
    logic [1:0] ev;

    assign avs_readdata = s_ff.rdata;
    assign avs_waitrequest = s_ff.waitreq;
    assign overflow_event = s_ff.ovf_req;
    assign match_capture_req = s_ff.mc_req;
    assign timer_interrupt_level = s_ff.irq;

    always_comb begin
        // prescaler is free running so every divided rate is a one-cycle pulse
        case (s_ff.ctl.clksel)
            sbt_pkg::sbt_clk_div4: tick = (s_ff.prescale[1:0] == 2'h3);
            sbt_pkg::sbt_clk_div8: tick = (s_ff.prescale[2:0] == 3'h7);
            sbt_pkg::sbt_clk_div16: tick = (s_ff.prescale == 4'hf);
            default: tick = carrier_ff & ~s_ff.carrier_q;
        endcase
        match_hit = tick && (s_ff.ctl.mode == sbt_pkg::sbt_mode_interval)
            && (s_ff.count == s_ff.refval);
        at_top = tick && (s_ff.count[CNT_W-1:0] == {CNT_W{1'b1}});
        case (s_ff.ctl.mode)
            sbt_pkg::sbt_mode_cap_rise: cap_hit = capture_input_pin & ~s_ff.cap_q;
            sbt_pkg::sbt_mode_cap_fall: cap_hit = ~capture_input_pin & s_ff.cap_q;
            sbt_pkg::sbt_mode_cap_both: cap_hit = capture_input_pin ^ s_ff.cap_q;
            default: cap_hit = 1'b0;
        endcase
        ev = {match_hit | cap_hit, at_top};
        ctl_wr = avs_write && (s_ff.bus == sbt_pkg::sbt_bus_idle) && avs_byteenable[0]
            && (avs_address == ADR_CONTROL) ? 1'b1 : 1'b0;
    end

    always_comb begin
        nxt_s = s_ff;
        nxt_s.prescale = s_ff.prescale + 4'h1;
        nxt_s.carrier_q = carrier_ff;
        nxt_s.cap_q = capture_input_pin;
        if (at_top || match_hit) begin
            nxt_s.count = '0;
        end else if (tick) begin
            nxt_s.count = s_ff.count + 16'h0001;
        end
        nxt_s.waitreq = 1'b1;
        nxt_s.rdata = 32'h0000_0000;
        // one wait cycle: request taken in idle, answered next cycle
        case (s_ff.bus)
            sbt_pkg::sbt_bus_idle: begin
                if (avs_read || avs_write) begin
                    nxt_s.bus = sbt_pkg::sbt_bus_answer;
                    nxt_s.waitreq = 1'b0;
                end
                if (avs_read) begin
                    if (avs_address == ADR_CNT_HIGH) begin
                        nxt_s.rdata[7:0] = s_ff.count[15:8];
                    end else if (avs_address == ADR_CNT_LOW) begin
                        nxt_s.rdata[7:0] = s_ff.count[7:0];
                    end else if (avs_address == ADR_REF_HIGH) begin
                        nxt_s.rdata[7:0] = s_ff.refval[15:8];
                    end else if (avs_address == ADR_REF_LOW) begin
                        nxt_s.rdata[7:0] = s_ff.refval[7:0];
                    end else if (avs_address == ADR_CONTROL) begin
                        // clear bit always reads zero
                        nxt_s.rdata[7:0] = {s_ff.ctl.clksel, s_ff.ctl.mode, 1'b0,
                            s_ff.ctl.ovf_en, s_ff.ctl.mc_en, s_ff.ctl.mc_pend};
                    end else if (avs_address == ADR_STATUS) begin
                        nxt_s.rdata[1:0] = s_ff.status;
                    end else if (avs_address == ADR_MASK) begin
                        nxt_s.rdata[1:0] = s_ff.mask;
                    end else begin
                        nxt_s.rdata = 32'h0000_0000;
                    end
                end else if (avs_write && avs_byteenable[0]) begin
                    if (avs_address == ADR_REF_HIGH) begin
                        nxt_s.refval[15:8] = avs_writedata[7:0];
                    end else if (avs_address == ADR_REF_LOW) begin
                        nxt_s.refval[7:0] = avs_writedata[7:0];
                    end else if (avs_address == ADR_CONTROL) begin
                        nxt_s.ctl.clksel = sbt_pkg::sbt_clksel_t'(avs_writedata[7:6]);
                        nxt_s.ctl.mode = sbt_pkg::sbt_mode_t'(avs_writedata[5:4]);
                        nxt_s.ctl.ovf_en = avs_writedata[`SBT_CTL_OVF_EN];
                        nxt_s.ctl.mc_en = avs_writedata[`SBT_CTL_MC_EN];
                        if (avs_writedata[`SBT_CTL_CLEAR]) begin
                            nxt_s.count = '0;
                        end
                    end else if (avs_address == ADR_MASK) begin
                        nxt_s.mask = avs_writedata[1:0];
                    end
                end
            end
            default: begin
                nxt_s.bus = sbt_pkg::sbt_bus_idle;
            end
        endcase
        // capture wins over a software write to the reference in the same cycle
        if (cap_hit) begin
            nxt_s.refval = s_ff.count;
        end
        // pending clears only by writing zero; a new event in that cycle wins
        if (ctl_wr && !avs_writedata[`SBT_CTL_MC_PEND]) begin
            nxt_s.ctl.mc_pend = 1'b0;
        end
        if (ev[1]) begin
            nxt_s.ctl.mc_pend = 1'b1;
        end
        if (avs_write && (s_ff.bus == sbt_pkg::sbt_bus_idle) && avs_byteenable[0]
            && (avs_address == ADR_STATUS)) begin
            nxt_s.status = s_ff.status & ~avs_writedata[1:0];
        end
        nxt_s.status = nxt_s.status | ev;
        // requests gated by enables; overflow request suppresses the match/capture request in the same cycle
        nxt_s.ovf_req = s_ff.ctl.ovf_en && at_top;
        nxt_s.mc_req = nxt_s.ctl.mc_pend && s_ff.ctl.mc_en && !(s_ff.ctl.ovf_en && at_top);
        nxt_s.irq = |(nxt_s.status & s_ff.mask);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    sequence top_tick_s;
        at_top;
    endsequence

    count_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
        top_tick_s |=> s_ff.count == 16'h0000) else $error("counter did not wrap");
    ovf_req_a: assert property (@(posedge sys_clk) disable iff (rst)
        (top_tick_s and s_ff.ctl.ovf_en) |=> overflow_event) else $error("overflow not requested");
    ovf_off_a: assert property (@(posedge sys_clk) disable iff (rst)
        overflow_event |-> $past(s_ff.ctl.ovf_en)) else $error("overflow while disabled");
    match_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && s_ff.ctl.mode == sbt_pkg::sbt_mode_interval && s_ff.count == s_ff.refval)
        |=> s_ff.count == 16'h0000 && s_ff.ctl.mc_pend) else $error("match did not clear count");
    match_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
        s_ff.ctl.mode != sbt_pkg::sbt_mode_interval |-> !match_hit) else $error("match outside interval");
    capture_copy_a: assert property (@(posedge sys_clk) disable iff (rst)
        cap_hit |=> s_ff.refval == $past(s_ff.count) && s_ff.ctl.mc_pend) else $error("capture not stored");
    rise_cap_a: assert property (@(posedge sys_clk) disable iff (rst)
        (s_ff.ctl.mode == sbt_pkg::sbt_mode_cap_rise && $rose(capture_input_pin)) |-> cap_hit)
        else $error("rising edge missed");
    clear_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ctl_wr && avs_writedata[3]) |=> s_ff.count == 16'h0000) else $error("clear bit ignored");
    prio_a: assert property (@(posedge sys_clk) disable iff (rst)
        overflow_event |-> !match_capture_req) else $error("match beat overflow");
    div4_a: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && s_ff.ctl.clksel == sbt_pkg::sbt_clk_div4) |=> !tick [*3]) else $error("div4 tick spacing");
    bus_ans_a: assert property (@(posedge sys_clk) disable iff (rst)
        (avs_read && s_ff.bus == sbt_pkg::sbt_bus_idle) |=> !avs_waitrequest) else $error("read not answered");

    // request steps: taken in idle, then the decoded target
    sequence bus_take_s;
        (avs_read || avs_write) && s_ff.bus == sbt_pkg::sbt_bus_idle;
    endsequence

    sequence wr_take_s;
        avs_write && s_ff.bus == sbt_pkg::sbt_bus_idle && avs_byteenable[0];
    endsequence

    sequence rd_take_s;
        avs_read && s_ff.bus == sbt_pkg::sbt_bus_idle;
    endsequence

    sequence cnt_write_s;
        wr_take_s ##0 (avs_address == ADR_CNT_HIGH || avs_address == ADR_CNT_LOW);
    endsequence

    sequence ovf_tick_s;
        at_top && s_ff.ctl.ovf_en;
    endsequence

    bus_any_a: assert property (@(posedge sys_clk) disable iff (rst)
        bus_take_s
        |=> !avs_waitrequest)
        else $error("request not answered");

    answer_one_a: assert property (@(posedge sys_clk) disable iff (rst)
        s_ff.bus == sbt_pkg::sbt_bus_answer
        |=> avs_waitrequest)
        else $error("answer held too long");

    ref_low_wr_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_take_s ##0 (avs_address == ADR_REF_LOW && !cap_hit))
        |=> s_ff.refval[7:0] == $past(avs_writedata[7:0]))
        else $error("reference low not written");

    ref_high_wr_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_take_s ##0 (avs_address == ADR_REF_HIGH && !cap_hit))
        |=> s_ff.refval[15:8] == $past(avs_writedata[7:0]))
        else $error("reference high not written");

    cnt_ro_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cnt_write_s ##0 !tick)
        |=> $stable(s_ff.count))
        else $error("counter byte took a write");

    cnt_low_rd_a: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_take_s ##0 avs_address == ADR_CNT_LOW)
        |=> avs_readdata == {24'h00_0000, $past(s_ff.count[7:0])})
        else $error("counter low read wrong");

    cnt_high_rd_a: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_take_s ##0 avs_address == ADR_CNT_HIGH)
        |=> avs_readdata == {24'h00_0000, $past(s_ff.count[15:8])})
        else $error("counter high read wrong");

    ctl_rd_a: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_take_s ##0 avs_address == ADR_CONTROL)
        |=> avs_readdata[3] == 1'b0 && avs_readdata[31:8] == 24'h00_0000)
        else $error("clear bit read back");

    pend_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ctl_wr && !avs_writedata[`SBT_CTL_MC_PEND] && !ev[1])
        |=> !s_ff.ctl.mc_pend)
        else $error("pending not cleared");

    pend_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ctl_wr && avs_writedata[`SBT_CTL_MC_PEND] && s_ff.ctl.mc_pend)
        |=> s_ff.ctl.mc_pend)
        else $error("pending lost on write of one");

    pend_set_a: assert property (@(posedge sys_clk) disable iff (rst)
        ev[1]
        |=> s_ff.ctl.mc_pend && s_ff.status[`SBT_ST_MC])
        else $error("event not pending");

    mc_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
        match_capture_req
        |-> $past(s_ff.ctl.mc_en))
        else $error("match request while disabled");

    count_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && !at_top && !match_hit && !ctl_wr)
        |=> s_ff.count == $past(s_ff.count) + 16'h0001)
        else $error("counter did not step");

    count_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!tick && !ctl_wr)
        |=> $stable(s_ff.count))
        else $error("counter moved without tick");

    div8_a: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && s_ff.ctl.clksel == sbt_pkg::sbt_clk_div8 && !ctl_wr)
        |=> !tick [*7])
        else $error("div8 tick spacing");

    carrier_tick_a: assert property (@(posedge sys_clk) disable iff (rst)
        (s_ff.ctl.clksel == sbt_pkg::sbt_clk_carrier && $rose(carrier_ff))
        |-> tick)
        else $error("carrier rise missed");

    mode_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
        (s_ff.ctl.mode != sbt_pkg::sbt_mode_interval && !cap_hit && !s_ff.ctl.mc_pend)
        |=> !s_ff.ctl.mc_pend)
        else $error("pending without capture");

    fall_skip_a: assert property (@(posedge sys_clk) disable iff (rst)
        (s_ff.ctl.mode == sbt_pkg::sbt_mode_cap_rise && $fell(capture_input_pin))
        |-> !cap_hit)
        else $error("falling edge taken in rise mode");

    fall_cap_a: assert property (@(posedge sys_clk) disable iff (rst)
        (s_ff.ctl.mode == sbt_pkg::sbt_mode_cap_fall && $fell(capture_input_pin))
        |-> cap_hit)
        else $error("falling edge missed");

    both_cap_a: assert property (@(posedge sys_clk) disable iff (rst)
        (s_ff.ctl.mode == sbt_pkg::sbt_mode_cap_both && $changed(capture_input_pin))
        |-> cap_hit)
        else $error("edge missed in both mode");

    ovf_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
        ovf_tick_s
        |=> overflow_event ##1 !overflow_event)
        else $error("overflow not one pulse");

    irq_level_a: assert property (@(posedge sys_clk) disable iff (rst)
        1'b1
        |=> timer_interrupt_level == |(s_ff.status & $past(s_ff.mask)))
        else $error("interrupt level wrong");

    mask_wr_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_take_s ##0 avs_address == ADR_MASK)
        |=> s_ff.mask == $past(avs_writedata[1:0]))
        else $error("mask not written");

    reset_ctl_a: assert property (@(posedge sys_clk)
        $past(rst)
        |-> s_ff.ctl == '0 && s_ff.count == '0)
        else $error("reset left control set");
endmodule

// file: hw/sbt_map.svh
// Purpose: register offsets, field positions, reset values and timing counts of the 16-bit capture timer
// Assumes: byte-wide registers, each in one aligned Avalon word
// Notes: byte address is four times the low six bits of the register index
`ifndef SBT_MAP_SVH
`define SBT_MAP_SVH
`define SBT_IDX_CNT_HIGH 8'hf6
`define SBT_IDX_CNT_LOW 8'hf7
`define SBT_IDX_REF_HIGH 8'hf8
`define SBT_IDX_REF_LOW 8'hf9
`define SBT_IDX_CONTROL 8'hfa
`define SBT_IDX_IRQ_STATUS 8'hfb
`define SBT_IDX_IRQ_MASK 8'hfc
`define SBT_CTL_CLKSEL_HI 7
`define SBT_CTL_CLKSEL_LO 6
`define SBT_CTL_MODE_HI 5
`define SBT_CTL_MODE_LO 4
`define SBT_CTL_CLEAR 3
`define SBT_CTL_OVF_EN 2
`define SBT_CTL_MC_EN 1
`define SBT_CTL_MC_PEND 0
`define SBT_CTL_RESET 8'h00
`define SBT_REF_RESET 16'h0000
`define SBT_ST_OVF 0
`define SBT_ST_MC 1
`define SBT_DIV4 4
`define SBT_DIV8 8
`define SBT_DIV16 16
`endif

// file: hw/sbt_pkg.sv
// Purpose: types of the 16-bit capture timer
// Assumes: constants come from sbt_map.svh
// Notes: one packed state struct per module
package sbt_pkg;
    typedef enum logic [1:0] {
        sbt_clk_div4,
        sbt_clk_div8,
        sbt_clk_div16,
        sbt_clk_carrier
    } sbt_clksel_t;
    typedef enum logic [1:0] {
        sbt_mode_interval,
        sbt_mode_cap_rise,
        sbt_mode_cap_fall,
        sbt_mode_cap_both
    } sbt_mode_t;
    typedef enum logic [1:0] {
        sbt_bus_idle,
        sbt_bus_answer
    } sbt_bus_t;
    typedef struct packed {
        sbt_clksel_t clksel;
        sbt_mode_t mode;
        logic ovf_en;
        logic mc_en;
        logic mc_pend;
    } sbt_ctl_t;
    typedef struct packed {
        sbt_ctl_t ctl;
        logic [15:0] count;
        logic [15:0] refval;
        logic [3:0] prescale;
        logic carrier_q;
        logic cap_q;
        logic [1:0] status;
        logic [1:0] mask;
        logic irq;
        logic ovf_req;
        logic mc_req;
        sbt_bus_t bus;
        logic waitreq;
        logic [31:0] rdata;
    } sbt_state_t;
endpackage

// file: verification/sbt_pin_model.sv
// Purpose: far-side source of the capture pin and carrier flip-flop
// Assumes: both lines are synchronous to sys_clk
// Notes: carrier stands still unless run is high
`timescale 1ns/100ps
module sbt_pin_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic toggle,
    input wire logic carrier_run,
    output logic capture_input_pin,
    output logic carrier_ff
);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            capture_input_pin <= 1'b0;
            carrier_ff <= 1'b0;
        end else begin
            capture_input_pin <= toggle ? ~capture_input_pin : capture_input_pin;
            // one rise per two cycles keeps the timer clock slower than sys_clk
            carrier_ff <= carrier_run ? ~carrier_ff : carrier_ff;
        end
    end
endmodule

// file: verification/sixteen_bit_timer_capture_tb.sv
// Purpose: self-checking bench of the 16-bit capture timer
// Assumes: counter narrowed to 8 bits so overflow comes quickly
// Notes: register index i sits at byte address 4*(i mod 64)
`timescale 1ns/100ps
`include "sbt_map.svh"
module sixteen_bit_timer_capture_tb;
    localparam int CW = 8;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic tg = 1'b0;
    logic run = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic [31:0] v;
    logic wreq, ovf, mcr, irq, pin, car;
    int num_errors = 0;
    int check_count = 0;
    int n;
    int nv;
    sbt_timer #(.CNT_W(CW)) u_sbt_timer (.sys_clk(sys_clk), .rst(rst), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'h1), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .capture_input_pin(pin), .carrier_ff(car), .overflow_event(ovf), .match_capture_req(mcr),
        .timer_interrupt_level(irq));
    sbt_pin_model u_sbt_pin_model (.sys_clk(sys_clk), .rst(rst), .toggle(tg), .carrier_run(run),
        .capture_input_pin(pin), .carrier_ff(car));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        adr <= {idx[5:0], 2'b00};
        wd <= {24'h0, d};
        rd <= ~w;
        wr <= w;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wreq !== 1'b0 && k < 100);
        v = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k >= 100)
            num_errors++;
        @(posedge sys_clk);
    endtask
    task automatic wait_ovf();
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ovf !== 1'b1 && n < 6000);
    endtask
    task automatic flip();
        tg <= 1'b1;
        @(posedge sys_clk);
        tg <= 1'b0;
        repeat (5) @(posedge sys_clk);
    endtask
    function automatic logic cap_exp(int m, logic lvl);
        return m == 3 || (m == 1 && lvl) || (m == 2 && !lvl);
    endfunction
    // reference zero matches every tick after reset, so pending is up
    function automatic logic [31:0] rst_exp(logic [7:0] idx);
        return (idx == `SBT_IDX_CONTROL) ? 32'h01 : ((idx == `SBT_IDX_IRQ_STATUS) ? 32'h02 : 32'h0);
    endfunction
    function automatic int per(int c);
        return (c == 3) ? (2 << CW) : ((4 << c) << CW);
    endfunction
    initial begin
        #2000000;
        num_errors++;
        results();
    end
    initial begin
        void'($urandom(32'h71b627a7));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        for (int i = 8'hf8; i <= 8'hfc; i++) begin
            bus(1'b0, i[7:0], 8'h00);
            chk(v, rst_exp(i[7:0]));
        end
        bus(1'b0, 8'h10, 8'h00);
        chk(v, 32'h0);
        bus(1'b1, `SBT_IDX_CONTROL, 8'h08);
        bus(1'b1, `SBT_IDX_CNT_LOW, 8'hff);
        bus(1'b0, `SBT_IDX_CNT_LOW, 8'h00);
        chk({31'h0, v < 32'h4}, 32'h1);
        nv = $urandom;
        bus(1'b1, `SBT_IDX_REF_HIGH, nv[15:8]);
        bus(1'b1, `SBT_IDX_REF_LOW, nv[7:0]);
        bus(1'b0, `SBT_IDX_REF_HIGH, 8'h00);
        chk(v, {24'h0, nv[15:8]});
        bus(1'b0, `SBT_IDX_REF_LOW, 8'h00);
        chk(v, {24'h0, nv[7:0]});
        // short reference brings the first match well inside the 60-cycle check
        nv = 4 + $urandom % 4;
        bus(1'b1, `SBT_IDX_REF_HIGH, 8'h00);
        bus(1'b1, `SBT_IDX_REF_LOW, nv[7:0]);
        bus(1'b1, `SBT_IDX_CONTROL, 8'h0a);
        n = 0;
        while (mcr !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        chk({31'h0, n < 60}, 32'h1);
        bus(1'b0, `SBT_IDX_CNT_LOW, 8'h00);
        chk({31'h0, v < 32'h3}, 32'h1);
        bus(1'b0, `SBT_IDX_CONTROL, 8'h00);
        chk(v, 32'h03);
        bus(1'b0, `SBT_IDX_IRQ_STATUS, 8'h00);
        chk(v & 32'h2, 32'h2);
        bus(1'b1, `SBT_IDX_CONTROL, 8'h12);
        repeat (60) @(posedge sys_clk);
        bus(1'b0, `SBT_IDX_CONTROL, 8'h00);
        chk(v, 32'h12);
        bus(1'b1, `SBT_IDX_IRQ_MASK, 8'h02);
        bus(1'b1, `SBT_IDX_IRQ_STATUS, 8'h03);
        bus(1'b1, `SBT_IDX_CONTROL, 8'h1a);
        flip();
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, `SBT_IDX_REF_LOW, 8'h00);
        chk({31'h0, v < 32'h8}, 32'h1);
        for (int m = 1; m < 4; m++) begin
            repeat (2) begin
                bus(1'b1, `SBT_IDX_CONTROL, {2'b00, m[1:0], 4'h2});
                flip();
                bus(1'b0, `SBT_IDX_CONTROL, 8'h00);
                chk({31'h0, v[0]}, {31'h0, cap_exp(m, pin)});
            end
        end
        bus(1'b1, `SBT_IDX_IRQ_STATUS, 8'h02);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, `SBT_IDX_REF_HIGH, 8'hff);
        bus(1'b1, `SBT_IDX_REF_LOW, 8'hff);
        bus(1'b1, `SBT_IDX_CONTROL, 8'h00);
        wait_ovf();
        chk(n, 32'd6000);
        for (int c = 0; c < 4; c++) begin
            run <= (c == 3);
            bus(1'b1, `SBT_IDX_CONTROL, {c[1:0], 6'h04});
            // first period after a select change may be short
            wait_ovf();
            wait_ovf();
            chk(n, per(c));
        end
        bus(1'b0, `SBT_IDX_IRQ_STATUS, 8'h00);
        chk(v & 32'h1, 32'h1);
        results();
    end
endmodule
